// ===== rtl/phy_mgmt_regbank.sv
// Clause-22 management register bank, registers 0 to 10
`timescale 1ns/100ps
`include "phy_mgmt_regs.svh"

module phy_mgmt_regbank #(
  parameter logic [4:0] PORT_ADDRESS = 5'h01,
  parameter logic [15:0] IDENT_HIGH = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] IDENT_LOW = 16'h5a51 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [1:0] advertise_strap_pair,
  input wire logic mgmt_clk,
  input wire logic mgmt_data_in,
  output logic mgmt_data_out,
  output logic mgmt_data_oe,
  input wire logic line_link_up,
  input wire logic remote_fault_event,
  input wire logic jabber_event,
  input wire logic neg_done,
  input wire logic [15:0] partner_base_word,
  input wire logic partner_base_load,
  input wire logic [15:0] partner_next_word,
  input wire logic partner_next_load,
  input wire logic parallel_fault_event,
  input wire logic partner_np_able,
  input wire logic partner_neg_able,
  input wire logic tx_toggle,
  input wire logic ms_fault_event,
  input wire logic ms_resolved_master,
  input wire logic local_rx_ok,
  input wire logic [7:0] mac_txd,
  input wire logic mac_tx_ctl,
  input wire logic [7:0] line_rxd,
  input wire logic line_rx_ctl,
  output logic [7:0] mac_rxd,
  output logic mac_rx_ctl,
  output logic mac_if_oe,
  output logic link_enable,
  output logic transceiver_reset,
  output logic neg_restart,
  output logic neg_enable,
  output logic [1:0] link_speed,
  output logic full_duplex,
  output logic power_down,
  output logic [2:0] test_mode,
  output logic force_master,
  output logic force_role,
  output logic prefer_master
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] clk_sync; // Management clock, two stages
  logic [1:0] dat_sync; // Management data, two stages
  logic clk_prev; // Previous synchronised clock
  logic [1:0] strap_meta; // Strap pins, first stage
  logic [1:0] strap_sync; // Strap pins, second stage

  // Two flops on the management clock, management data and strap pins before use
  always_ff @(posedge sys_clk) begin
    clk_sync <= {clk_sync[0], mgmt_clk};
    dat_sync <= {dat_sync[0], mgmt_data_in};
    strap_meta <= advertise_strap_pair;
    strap_sync <= strap_meta;
    clk_prev <= clk_sync[1];
  end

  wire clk_rise = clk_sync[1] & ~clk_prev; // Sample edge
  wire clk_fall = ~clk_sync[1] & clk_prev; // Drive edge
  wire mdi = dat_sync[1]; // Sampled data bit

  // ---------------------------------------------------------------
  // Frame walker
  // ---------------------------------------------------------------
  phy_mgmt_pkg::frame_state_e state; // Walker state
  logic [5:0] bit_cnt; // Bits left in a field
  logic [11:0] head; // Opcode, port, register
  logic [15:0] shift; // Data shift register
  logic is_read; // Current frame reads
  logic [4:0] reg_addr; // Latched register address
  logic wr_pulse; // One-cycle register write
  logic rd_pulse; // One-cycle register read
  logic [15:0] rd_word; // Word chosen for a read

  wire [1:0] head_op = head[11:10]; // Opcode field
  wire head_hit = head[9:5] == PORT_ADDRESS; // Port address match

  // Start, opcode, port, register, turnaround, data in order
  always_ff @(posedge sys_clk) begin
    wr_pulse <= 1'b0;
    rd_pulse <= 1'b0;
    if (srst) begin
      state <= phy_mgmt_pkg::FR_IDLE;
      bit_cnt <= 6'd0;
      head <= 12'h000;
      shift <= 16'h0000;
      is_read <= 1'b0;
      reg_addr <= 5'h00;
      mgmt_data_oe <= 1'b0;
      mgmt_data_out <= 1'b1;
    end else begin
      case (state)
        phy_mgmt_pkg::FR_IDLE: begin
          mgmt_data_oe <= 1'b0;
          // Start on first zero, no preamble demanded
          if (clk_rise && !mdi) begin
            state <= phy_mgmt_pkg::FR_START;
          end
        end
        phy_mgmt_pkg::FR_START: begin
          if (clk_rise) begin
            state <= mdi ? phy_mgmt_pkg::FR_HEAD : phy_mgmt_pkg::FR_IDLE;
            bit_cnt <= 6'd12;
          end
        end
        phy_mgmt_pkg::FR_HEAD: begin
          if (clk_rise) begin
            head <= {head[10:0], mdi};
            bit_cnt <= bit_cnt - 6'd1;
            if (bit_cnt == 6'd1) begin
              state <= phy_mgmt_pkg::FR_TURN;
              bit_cnt <= 6'd2;
            end
          end
        end
        phy_mgmt_pkg::FR_TURN: begin
          reg_addr <= head[4:0];
          is_read <= head_op == `OP_READ;
          if (!(head_hit && (head_op == `OP_READ ||
              head_op == `OP_WRITE))) begin
            state <= phy_mgmt_pkg::FR_SKIP;
            bit_cnt <= 6'd18;
          end else if (clk_rise) begin
            bit_cnt <= bit_cnt - 6'd1;
            if (bit_cnt == 6'd1) begin
              state <= phy_mgmt_pkg::FR_DATA;
              bit_cnt <= 6'd16;
            end
          end else if (clk_fall && is_read && bit_cnt == 6'd1) begin
            // Second turnaround bit driven low, then data
            mgmt_data_oe <= 1'b1;
            mgmt_data_out <= 1'b0;
            shift <= rd_word;
            rd_pulse <= 1'b1;
          end
        end
        phy_mgmt_pkg::FR_DATA: begin
          if (is_read && clk_fall) begin
            mgmt_data_out <= shift[15];
            shift <= {shift[14:0], 1'b0};
          end
          if (clk_rise) begin
            if (!is_read) begin
              shift <= {shift[14:0], mdi};
            end
            bit_cnt <= bit_cnt - 6'd1;
            if (bit_cnt == 6'd1) begin
              state <= phy_mgmt_pkg::FR_IDLE;
              wr_pulse <= !is_read;
            end
          end
        end
        phy_mgmt_pkg::FR_SKIP: begin
          if (clk_rise) begin
            bit_cnt <= bit_cnt - 6'd1;
            if (bit_cnt == 6'd1) begin
              state <= phy_mgmt_pkg::FR_IDLE;
            end
          end
        end
        default: begin
          state <= phy_mgmt_pkg::FR_IDLE;
        end
      endcase
    end
  end

  // Write data once the last bit is in
  wire [15:0] wdata = shift;

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  logic [15:0] basic_control; // Control register
  logic [15:0] negotiation_advertisement; // Advertisement
  logic [15:0] next_page_transmit; // Next page transmit
  logic [15:0] gigabit_control; // Gigabit control
  logic [3:0] action_cnt; // Self-clear pulse stretch
  logic strap_done; // Strap defaults applied

  // Strap decode: gigabit half only in 01 and 11
  wire strap_gig_half = strap_sync[0];
  wire strap_low_speed = strap_sync[1];

  wire wr_bc = wr_pulse && reg_addr == `OFS_BASIC_CONTROL;
  wire wr_adv = wr_pulse && reg_addr == `OFS_NEG_ADVERT;
  wire wr_np = wr_pulse && reg_addr == `OFS_NEXT_PAGE_TX;
  wire wr_gc = wr_pulse && reg_addr == `OFS_GIG_CONTROL;

  // Masked write, read-only bits keep their value
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] data,
                                        input logic [15:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  // Control register with self-clearing action bits
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      basic_control <= `BC_RESET_VAL;
      action_cnt <= 4'd0;
    end else if (wr_bc) begin
      basic_control <= merge(basic_control, wdata, `BC_WRITE_MASK);
      action_cnt <= `ACTION_PULSE_CYCLES;
    end else begin
      if (action_cnt != 4'd0) begin
        action_cnt <= action_cnt - 4'd1;
      end else begin
        basic_control[`BC_RESET] <= 1'b0;
        basic_control[`BC_RESTART] <= 1'b0;
      end
    end
  end

  // Advertisement and gigabit control strap-seeded after reset release, plus next page
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      negotiation_advertisement <= {11'h000, `ADV_SELECTOR};
      next_page_transmit <= `NP_RESET_VAL;
      gigabit_control <= `GC_RESET_BASE;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      negotiation_advertisement[8:5] <= {4{strap_low_speed}};
      gigabit_control[`GC_HALF_BIT] <= strap_gig_half;
    end else begin
      if (wr_adv) begin
        negotiation_advertisement <= merge(negotiation_advertisement,
                                           wdata, `ADV_WRITE_MASK);
      end
      if (wr_np) begin
        next_page_transmit <= merge(next_page_transmit, wdata,
                                    `NP_WRITE_MASK);
      end
      if (wr_gc) begin
        gigabit_control <= merge(gigabit_control, wdata,
                                 `GC_WRITE_MASK);
      end
    end
  end

  // ---------------------------------------------------------------
  // Latched status bits and partner pages
  // ---------------------------------------------------------------
  logic remote_fault; // Latched high
  logic jabber; // Latched high
  logic link_latched; // Latched low
  logic parallel_fault; // Latched high
  logic page_received; // Latched high
  logic ms_fault; // Latched high
  logic [15:0] partner_base_page; // Received base page
  logic [15:0] partner_next_page; // Received next page

  wire rd_bs = rd_pulse && reg_addr == `OFS_BASIC_STATUS;
  wire rd_ex = rd_pulse && reg_addr == `OFS_NEG_EXPANSION;
  wire rd_gs = rd_pulse && reg_addr == `OFS_GIG_STATUS;
  wire link_now = line_link_up && !basic_control[`BC_LOOPBACK];

  // Events win over a clearing read in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      remote_fault <= 1'b0;
      jabber <= 1'b0;
      link_latched <= 1'b0;
      parallel_fault <= 1'b0;
      page_received <= 1'b0;
      ms_fault <= 1'b0;
    end else begin
      remote_fault <= remote_fault_event | (remote_fault & ~rd_bs);
      jabber <= jabber_event | (jabber & ~rd_bs);
      link_latched <= link_now & (link_latched | rd_bs);
      parallel_fault <= parallel_fault_event |
                        (parallel_fault & ~rd_ex);
      page_received <= partner_base_load | partner_next_load |
                       (page_received & ~rd_ex);
      ms_fault <= ms_fault_event | (ms_fault & ~rd_gs);
    end
  end

  // Partner code words captured on load
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      partner_base_page <= 16'h0000;
      partner_next_page <= 16'h0000;
    end else begin
      if (partner_base_load) begin
        partner_base_page <= partner_base_word;
      end
      if (partner_next_load) begin
        partner_next_page <= partner_next_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  wire [15:0] basic_status = `BS_FIXED_ABILITY |
      {10'h000, neg_done && neg_enable, remote_fault, 1'b0,
       link_latched, jabber, 1'b0};
  wire [15:0] expansion = {11'h000, parallel_fault, partner_np_able,
      negotiation_advertisement[15], page_received, partner_neg_able};
  wire [15:0] np_view = {next_page_transmit[15:12], tx_toggle,
                         next_page_transmit[10:0]};
  wire [15:0] gig_status = {ms_fault, ms_resolved_master, local_rx_ok,
                            13'h0000};

  always_comb begin
    case (reg_addr)
      `OFS_BASIC_CONTROL: rd_word = basic_control;
      `OFS_BASIC_STATUS: rd_word = basic_status;
      `OFS_IDENT_HIGH: rd_word = IDENT_HIGH;
      `OFS_IDENT_LOW: rd_word = IDENT_LOW;
      `OFS_NEG_ADVERT: rd_word = negotiation_advertisement;
      `OFS_PARTNER_BASE: rd_word = partner_base_page;
      `OFS_NEG_EXPANSION: rd_word = expansion;
      `OFS_NEXT_PAGE_TX: rd_word = np_view;
      `OFS_PARTNER_NEXT: rd_word = partner_next_page;
      `OFS_GIG_CONTROL: rd_word = gigabit_control;
      `OFS_GIG_STATUS: rd_word = gig_status;
      default: rd_word = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Control outputs and data path
  // ---------------------------------------------------------------
  wire [2:0] tm_field = gigabit_control[15:13];
  wire tm_legal = tm_field <= phy_mgmt_pkg::TM_DISTORTION;
  assign transceiver_reset = basic_control[`BC_RESET];
  assign neg_restart = basic_control[`BC_RESTART];
  assign neg_enable = basic_control[`BC_NEG_ENABLE];
  assign power_down = basic_control[`BC_POWER_DOWN];
  assign link_enable = !basic_control[`BC_LOOPBACK];
  assign mac_if_oe = !basic_control[`BC_ISOLATE];
  assign test_mode = tm_legal ? tm_field : phy_mgmt_pkg::TM_NORMAL;
  assign force_master = gigabit_control[12];
  assign force_role = gigabit_control[12] & gigabit_control[11];
  assign prefer_master = ~gigabit_control[12] & gigabit_control[10];

  // Forced speed and duplex only without negotiation
  always_comb begin
    if (neg_enable) begin
      link_speed = 2'b10;
      full_duplex = 1'b1;
    end else begin
      link_speed = {basic_control[`BC_SPEED_MSB],
                    basic_control[`BC_SPEED_LSB]};
      full_duplex = basic_control[`BC_DUPLEX];
    end
  end

  // Receive path: loopback takes transmit data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mac_rxd <= 8'h00;
      mac_rx_ctl <= 1'b0;
    end else if (basic_control[`BC_LOOPBACK]) begin
      mac_rxd <= mac_txd;
      mac_rx_ctl <= mac_tx_ctl;
    end else begin
      mac_rxd <= line_rxd;
      mac_rx_ctl <= line_rx_ctl;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence read_status_seq;
    rd_bs ##1 !remote_fault_event;
  endsequence

  latch_rf_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    remote_fault_event |=> remote_fault)
    else $error("remote fault not latched");
  latch_rf_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    rd_bs && !remote_fault_event |=> !remote_fault)
    else $error("remote fault not cleared by read");
  self_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    wr_bc |-> ##[1:10] !transceiver_reset && !neg_restart)
    else $error("action bits did not clear");
  loop_rx_a: assert property (@(posedge sys_clk) disable iff (srst)
    basic_control[`BC_LOOPBACK] |=> mac_rxd == $past(mac_txd))
    else $error("loopback data wrong");
  forced_speed_a: assert property (@(posedge sys_clk) disable iff (srst)
    !neg_enable |-> link_speed == {basic_control[6],
                                   basic_control[13]})
    else $error("forced speed mismatch");
  isolate_oe_a: assert property (@(posedge sys_clk) disable iff (srst)
    basic_control[`BC_ISOLATE] |-> !mac_if_oe)
    else $error("isolate did not detach");
  fixed_ability_a: assert property (@(posedge sys_clk) disable iff (srst)
    (basic_status & 16'hfb49) == `BS_FIXED_ABILITY)
    else $error("ability bits wrong");
  link_low_a: assert property (@(posedge sys_clk) disable iff (srst)
    !link_now |=> !link_latched ##1
    (!link_latched || $past(rd_bs)))
    else $error("link loss not latched");
  selector_a: assert property (@(posedge sys_clk) disable iff (srst)
    negotiation_advertisement[4:0] == `ADV_SELECTOR)
    else $error("selector field changed");
  status_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    read_status_seq |-> !jabber || $past(jabber_event))
    else $error("jabber not cleared");

endmodule

// ===== rtl/phy_mgmt_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef PHY_MGMT_REGS_SVH
`define PHY_MGMT_REGS_SVH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define OFS_BASIC_CONTROL 5'h00
`define OFS_BASIC_STATUS 5'h01
`define OFS_IDENT_HIGH 5'h02
`define OFS_IDENT_LOW 5'h03
`define OFS_NEG_ADVERT 5'h04
`define OFS_PARTNER_BASE 5'h05
`define OFS_NEG_EXPANSION 5'h06
`define OFS_NEXT_PAGE_TX 5'h07
`define OFS_PARTNER_NEXT 5'h08
`define OFS_GIG_CONTROL 5'h09
`define OFS_GIG_STATUS 5'h0a

// -----------------------------------------------------------------
// Basic control field positions
// -----------------------------------------------------------------
`define BC_RESET 15
`define BC_LOOPBACK 14
`define BC_SPEED_LSB 13
`define BC_NEG_ENABLE 12
`define BC_POWER_DOWN 11
`define BC_ISOLATE 10
`define BC_RESTART 9
`define BC_DUPLEX 8
`define BC_COLL_TEST 7
`define BC_SPEED_MSB 6

// -----------------------------------------------------------------
// Reset values and fixed fields
// -----------------------------------------------------------------
`define BC_RESET_VAL 16'h1140
`define BC_WRITE_MASK 16'hffc0
`define BS_FIXED_ABILITY 16'h7949
`define ADV_SELECTOR 5'h01
`define ADV_WRITE_MASK 16'hade0
`define NP_RESET_VAL 16'h2001
`define NP_WRITE_MASK 16'hb7ff
`define GC_RESET_BASE 16'h0200
`define GC_WRITE_MASK 16'hff00
`define GC_HALF_BIT 8

// -----------------------------------------------------------------
// Management frame layout and timing
// -----------------------------------------------------------------
`define OP_WRITE 2'b01
`define OP_READ 2'b10
`define PREAMBLE_ONES 6'd32
`define ACTION_PULSE_CYCLES 4'd8

`endif

// ===== rtl/phy_mgmt_pkg.sv
// Types shared by the management register bank
package phy_mgmt_pkg;
  // Serial frame walker states, one-hot
  typedef enum logic [5:0] {
    FR_IDLE = 6'b000001,
    FR_START = 6'b000010,
    FR_HEAD = 6'b000100,
    FR_TURN = 6'b001000,
    FR_DATA = 6'b010000,
    FR_SKIP = 6'b100000
  } frame_state_e;

  // Gigabit test modes
  typedef enum logic [2:0] {
    TM_NORMAL = 3'b000,
    TM_WAVEFORM = 3'b001,
    TM_MASTER_JITTER = 3'b010,
    TM_SLAVE_JITTER = 3'b011,
    TM_DISTORTION = 3'b100
  } test_mode_e;
endpackage

// ===== testbench/mgmt_master.sv
// Station management master model for the serial management port
`timescale 1ns/100ps
module mgmt_master (
  output logic mdc,
  output logic mdo,
  output logic mdo_en,
  input wire logic mdio
);
  // ---------------------------------------------
  // Frame engine, clock stands low between frames
  // ---------------------------------------------
  initial begin
    mdc = 1'b0;
    mdo = 1'b1;
    mdo_en = 1'b0;
  end
  // Start, op, port, register, turnaround, data
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, input bit pre,
      output logic [15:0] rd);
    logic [31:0] w;
    w = {2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = (pre ? -32 : 0); i < 32; i++) begin
      // Let go of the line for turnaround and data of a read
      mdo_en = !(op == 2'b10 && i >= 14);
      mdo = (i < 0) ? 1'b1 : w[31 - i];
      #62.5 mdc = 1'b1;
      if (i >= 16) rd = {rd[14:0], mdio};
      #62.5 mdc = 1'b0;
    end
    mdo_en = 1'b0;
    #125;
  endtask
endmodule

// ===== testbench/tb_gbe_phy_base_mgmt_registers.sv
// Self-checking bench for the management register bank
`timescale 1ns/100ps
`include "phy_mgmt_regs.svh"
module tb_gbe_phy_base_mgmt_registers;
  localparam logic [15:0] ID_HI = 16'h1c3d; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'h4e5f; // Arbitrary value
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] strap = 2'b10;
  logic mdc, mdo, mdo_en, d_out, d_oe, mdio;
  logic lnk = 1'b0, rf = 1'b0, jab = 1'b0, nd = 1'b0, pf = 1'b0;
  logic pbl = 1'b0, pnl = 1'b0, npa = 1'b0, nea = 1'b0, tog = 1'b0;
  logic msf = 1'b0, msm = 1'b0, rxok = 1'b0, le, oe, ne, fd, fm, fr, pm;
  logic [7:0] txd = 8'h00, rxl = 8'h00, rxo;
  logic [1:0] spd;
  logic [2:0] tm;
  logic [15:0] pbw = 16'h0000, pnw = 16'h0000, wd, rd;
  logic [15:0] seed = 16'd60898;
  logic np_adv = 1'b0; // Last next-page advertisement written
  int bad_count = 0;
  int num_checks = 0;
  // Line level: pull-up while nobody drives
  assign mdio = d_oe ? d_out : (mdo_en ? mdo : 1'b1);
  always #4 sys_clk = ~sys_clk;
  phy_mgmt_regbank #(.IDENT_HIGH(ID_HI), .IDENT_LOW(ID_LO)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .advertise_strap_pair(strap),
    .mgmt_clk(mdc), .mgmt_data_in(mdio), .mgmt_data_out(d_out),
    .mgmt_data_oe(d_oe), .line_link_up(lnk), .remote_fault_event(rf),
    .jabber_event(jab), .neg_done(nd), .partner_base_word(pbw),
    .partner_base_load(pbl), .partner_next_word(pnw),
    .partner_next_load(pnl), .parallel_fault_event(pf),
    .partner_np_able(npa), .partner_neg_able(nea), .tx_toggle(tog),
    .ms_fault_event(msf), .ms_resolved_master(msm), .local_rx_ok(rxok),
    .mac_txd(txd), .mac_tx_ctl(txd[0]), .line_rxd(rxl),
    .line_rx_ctl(rxl[0]), .mac_rxd(rxo), .mac_rx_ctl(), .mac_if_oe(oe),
    .link_enable(le), .transceiver_reset(), .neg_restart(),
    .neg_enable(ne), .link_speed(spd), .full_duplex(fd), .power_down(),
    .test_mode(tm), .force_master(fm), .force_role(fr),
    .prefer_master(pm));
  mgmt_master i_mst (.mdc(mdc), .mdo(mdo), .mdo_en(mdo_en), .mdio(mdio));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected contents right after reset
  function automatic logic [15:0] rst_val(input logic [4:0] a);
    case (a)
      5'h00: return 16'h1140;
      5'h01: return 16'h7949;
      5'h02: return ID_HI;
      5'h03: return ID_LO;
      5'h04: return {7'h00, {4{strap[1]}}, 5'h01};
      5'h07: return 16'h2001;
      5'h09: return {6'h00, 1'b1, strap[0], 8'h00};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic chk(input logic [15:0] got, exp, m);
    num_checks++;
    if (((got ^ exp) & m) !== 16'h0000) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    i_mst.frame(`OP_WRITE, 5'h01, a, d, seed[1], x);
    seed = lfsr(seed);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, m);
    logic [15:0] d;
    i_mst.frame(`OP_READ, 5'h01, a, 16'h0000, seed[0], d);
    seed = lfsr(seed);
    chk(d, e, m);
  endtask
  task automatic do_reset();
    @(posedge sys_clk) srst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung frame
  initial begin
    #700000;
    bad_count++;
    complete_run();
  end
  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    do_reset();
    for (int a = 0; a < 11; a++)
      rd_chk(a[4:0], rst_val(a[4:0]), 16'hffff);
    $display("reset values done");
    repeat (4) begin
      wd = seed;
      np_adv = wd[15];
      @(posedge sys_clk) tog <= seed[5];
      wr_reg(`OFS_NEG_ADVERT, wd);
      rd_chk(`OFS_NEG_ADVERT, (wd & 16'hade0) | 16'h1, 16'hfdff);
      wr_reg(`OFS_NEXT_PAGE_TX, wd);
      rd_chk(`OFS_NEXT_PAGE_TX, (wd & 16'hb7ff) | {tog, 11'h0}, 16'hffff);
      wr_reg(`OFS_IDENT_HIGH, wd);
      rd_chk(`OFS_IDENT_HIGH, ID_HI, 16'hffff);
    end
    wr_reg(`OFS_BASIC_CONTROL, 16'h9340);
    rd_chk(`OFS_BASIC_CONTROL, 16'h0000, 16'h8200);
    $display("write access done");
    for (int k = 0; k < 3; k++) begin
      wd = {2'b00, k[0], 4'h0, k[0], 1'b0, k[1], 6'h00};
      wr_reg(`OFS_BASIC_CONTROL, wd);
      chk({14'h0, spd}, 16'(k), 16'hffff);
      chk({14'h0, ne, fd}, {15'h0, k[0]}, 16'hffff);
    end
    @(posedge sys_clk) txd <= seed[7:0];
    wr_reg(`OFS_BASIC_CONTROL, 16'h4400);
    chk({8'h0, rxo}, {8'h0, txd}, 16'hffff);
    chk({14'h0, le, oe}, 16'h0, 16'hffff);
    @(posedge sys_clk) rxl <= seed[15:8];
    wr_reg(`OFS_BASIC_CONTROL, 16'h1140);
    chk({8'h0, rxo}, {8'h0, rxl}, 16'hffff);
    chk({14'h0, le, oe}, 16'h3, 16'hffff);
    $display("control outputs done");
    @(posedge sys_clk) {rf, jab, lnk, nd} <= 4'hf;
    @(posedge sys_clk) {rf, jab} <= 2'b00;
    rd_chk(`OFS_BASIC_STATUS, 16'h797b, 16'hffff);
    rd_chk(`OFS_BASIC_STATUS, 16'h796d, 16'hffff);
    @(posedge sys_clk) lnk <= 1'b0;
    @(posedge sys_clk) {lnk, nd} <= 2'b10;
    rd_chk(`OFS_BASIC_STATUS, 16'h7949, 16'hffff);
    rd_chk(`OFS_BASIC_STATUS, 16'h794d, 16'hffff);
    @(posedge sys_clk) begin
      {pbw, pnw} <= {seed, ~seed};
      {pbl, pnl, pf, npa, nea, msf, rxok} <= 7'h7f;
      msm <= seed[3];
    end
    @(posedge sys_clk) {pbl, pnl, pf, msf} <= 4'h0;
    rd_chk(`OFS_PARTNER_BASE, pbw, 16'hffff);
    rd_chk(`OFS_PARTNER_NEXT, pnw, 16'hffff);
    rd_chk(`OFS_NEG_EXPANSION, {11'h0, 2'b11, np_adv, 2'b11},
           16'hffff);
    rd_chk(`OFS_NEG_EXPANSION, {11'h0, 2'b01, np_adv, 2'b01},
           16'hffff);
    rd_chk(`OFS_GIG_STATUS, {1'b1, msm, 14'h2000}, 16'hffff);
    rd_chk(`OFS_GIG_STATUS, {1'b0, msm, 14'h2000}, 16'hffff);
    $display("status bits done");
    for (int t = 0; t < 8; t++) begin
      wd = {t[2:0], seed[12:10], 2'b10, 8'h00};
      wr_reg(`OFS_GIG_CONTROL, wd);
      chk({13'h0, tm}, (t < 5) ? 16'(t) : 16'h0, 16'hffff);
      chk({13'h0, fm, fr, pm}, {13'h0, wd[12], wd[12] & wd[11],
          ~wd[12] & wd[10]}, 16'hffff);
    end
    rd_chk(`OFS_GIG_CONTROL, wd, 16'hffff);
    i_mst.frame(`OP_READ, 5'h02, `OFS_IDENT_LOW, 16'h0, 1'b0, rd);
    chk(rd, 16'hffff, 16'hffff);
    $display("gigabit control done");
    strap <= seed[1:0];
    do_reset();
    rd_chk(`OFS_NEG_ADVERT, rst_val(5'h04), 16'hffff);
    rd_chk(`OFS_GIG_CONTROL, rst_val(5'h09), 16'hffff);
    $display("strap reload done");
    complete_run();
  end
endmodule
